// ===== hw/rtc_cal_prescaler.sv
// Purpose: Divides the crystal down to the 1/128 s tick with trim correction.
// Assumes: The crystal level is synchronous to sys_clk.
// Notes:   Trim is accumulated once per second and spent one crystal edge at a time.

`timescale 1ns/10ps

module rtc_cal_prescaler
	import rtc_pkg::*;
#(
	parameter int W = PRESCALE_W
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              xtal_in,
	input  wire logic signed [8:0] trim_sum,
	input  wire logic              sec_tick,
	output logic                   fraction_tick
);

	logic                        xtal_prev;
	logic [W-1:0]                count;
	logic signed [CAL_ACC_W-1:0] cal_acc;
	logic                        next_tick;
	logic [W-1:0]                next_count;
	logic signed [CAL_ACC_W-1:0] next_acc;
	logic [1:0]                  step;
	logic [W:0]                  sum;
	logic                        edge_seen;

	assign edge_seen = xtal_in && !xtal_prev;

	// Positive trim counts an edge twice (crystal slow), negative trim skips one.
	always_comb begin
		step     = 2'h1;
		next_acc = cal_acc;
		if (sec_tick) begin
			next_acc = cal_acc + {{(CAL_ACC_W-9){trim_sum[8]}}, trim_sum};
		end
		if (edge_seen && (cal_acc >= CAL_STEP_UNITS)) begin
			step     = 2'h2;
			next_acc = next_acc - CAL_STEP_UNITS;
		end else if (edge_seen && (cal_acc <= -CAL_STEP_UNITS)) begin
			step     = 2'h0;
			next_acc = next_acc + CAL_STEP_UNITS;
		end
		sum        = {1'b0, count} + (W+1)'(step);
		next_count = edge_seen ? sum[W-1:0] : count;
		next_tick  = edge_seen && sum[W];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			xtal_prev     <= 1'b0;
			count         <= '0;
			cal_acc       <= '0;
			fraction_tick <= 1'b0;
		end else begin
			xtal_prev     <= xtal_in;
			count         <= next_count;
			cal_acc       <= next_acc;
			fraction_tick <= next_tick;
		end
	end

endmodule : rtc_cal_prescaler

// ===== hw/rtc_timekeeping_unit.sv
// Purpose: Real-time clock timekeeping unit with SFR access, alarm and midnight flag.
// Assumes: rst is the power-on reset; warm_rst is a watchdog or external pin reset.
// Notes:   Time counters and the day-wrap select survive warm_rst.
//
// Overview of operation
// [R1] Time base comes from 32.768 kHz crystal.
// [R2] Nominal and thermal trim correct the time base.
// [R3] Counting continues in every power-saving state.
// [R4] Counters survive warm reset, clear at power-on.
// [R5] Clock registers are byte-wide, not bit addressable.
// [R6] Protected writes need key 0xEA loaded first.
// [R7] Software relocks by zeroing the key afterwards.
// [R8] Midnight flag sets at rollover, software clears.
// [R9] Twenty-four hour mode flags midnight once daily.
// [R10] Midnight wake blocks deep sleep until cleared.
// [R11] Day-wrap select picks 255 or 23 wrap.
// [R12] Day-wrap select clears only at power-on.
// [R13] Interval base: fraction, second, minute or hour.
// [R14] Fraction counts 1/128 s, wraps at 127.
// [R15] Seconds wrap at 59 and carry minutes.
// [R16] Repeating or single-shot interval alarm.
// [R17] Interval off resets counter; needs run enable.

`timescale 1ns/10ps

module rtc_timekeeping_unit
	import rtc_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       warm_rst,
	input  wire logic       xtal_clk_in,
	input  wire logic       clock_run_enable,
	input  wire logic       deep_sleep_state,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr_en,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_rd_en,
	output logic      [7:0] sfr_rdata,
	output logic            sfr_hit,
	output logic            midnight_flag,
	output logic            alarm_flag,
	output logic            deep_sleep_block,
	output logic      [7:0] pin_interrupt_config
);

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	logic [7:0]      write_unlock_key;
	logic [7:0]      alarm_period;
	logic [7:0]      crystal_nominal_trim;
	logic [7:0]      crystal_thermal_trim;
	logic            day_wrap_select;
	logic [1:0]      interval_base_select;
	logic            single_shot_interval;
	logic            interval_timer_on;
	logic [7:0]      ivl_count;
	rtc_ivl_state_t  ivl_state;

	logic [7:0]      next_key;
	logic [7:0]      next_period;
	logic [7:0]      next_nominal;
	logic [7:0]      next_thermal;
	logic [7:0]      next_pin_cfg;
	logic            next_midnight;
	logic            next_alarm;
	logic            next_block;
	logic            next_day_wrap;
	logic [1:0]      next_base;
	logic            next_single_shot;
	logic            next_ivl_on;
	logic [7:0]      next_ivl_count;
	rtc_ivl_state_t  next_ivl_state;
	logic [7:0]      next_rdata;
	logic            next_hit;

	logic [7:0]      fraction_counter;
	logic [7:0]      one_hz_counter;
	logic [7:0]      per_sixty_s_counter;
	logic [7:0]      hour_counter;
	logic            fraction_tick;
	logic            frac_wrap;
	logic            sec_wrap;
	logic            min_wrap;
	logic            hour_wrap;
	logic            alarm_event;
	logic            ivl_tick;
	logic            ivl_run;
	logic            unlocked;
	logic            wr_ctrl;
	logic            wr_frac;
	logic            wr_sec;
	logic            wr_min;
	logic            wr_hour;
	logic [7:0]      hour_wrap_val;
	logic signed [8:0] trim_sum;
	logic [7:0]      ctrl_view;

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	// Only whole-byte writes exist; there is no bit-address path at all.
	assign unlocked = (write_unlock_key == UNLOCK_KEY_VALUE);    // see [R6]
	assign wr_ctrl  = sfr_wr_en && (sfr_addr == ADDR_RTC_CONTROL); // see [R5]
	assign wr_frac  = sfr_wr_en && unlocked && (sfr_addr == ADDR_FRACTION_COUNTER); // see [R6]
	assign wr_sec   = sfr_wr_en && unlocked && (sfr_addr == ADDR_ONE_HZ_COUNTER); // see [R6]
	assign wr_min   = sfr_wr_en && unlocked && (sfr_addr == ADDR_PER_SIXTY_S); // see [R6]
	assign wr_hour  = sfr_wr_en && unlocked && (sfr_addr == ADDR_HOUR_COUNTER); // see [R6]

	// ------------------------------------------------------------------
	// Calibrated time base
	// ------------------------------------------------------------------
	// Trim values are two's complement; the sum cannot overflow nine bits.
	assign trim_sum = {crystal_nominal_trim[7], crystal_nominal_trim}
		+ {crystal_thermal_trim[7], crystal_thermal_trim}; // see [R2]

	// The prescaler has no power-state gating, so time runs in every mode.
	rtc_cal_prescaler #(
		.W             (PRESCALE_W)
	) u_prescaler (
		.clk           (sys_clk),
		.rst           (rst),
		.xtal_in       (xtal_clk_in),
		.trim_sum      (trim_sum),
		.sec_tick      (frac_wrap),
		.fraction_tick (fraction_tick)
	); // see [R1] see [R3] see [R4]

	// ------------------------------------------------------------------
	// Time counters
	// ------------------------------------------------------------------
	assign hour_wrap_val = day_wrap_select ? HOUR_WRAP_24 : HOUR_WRAP_256; // see [R11]

	rtc_wrap_counter #(.W(8)) u_fraction (
		.clk       (sys_clk),
		.rst       (rst),
		.inc       (fraction_tick),
		.wrap_val  (FRACTION_WRAP),
		.load      (wr_frac),
		.load_data (sfr_wdata),
		.count     (fraction_counter),
		.carry     (frac_wrap)
	); // see [R14] see [R4]

	rtc_wrap_counter #(.W(8)) u_seconds (
		.clk       (sys_clk),
		.rst       (rst),
		.inc       (frac_wrap),
		.wrap_val  (SECOND_WRAP),
		.load      (wr_sec),
		.load_data (sfr_wdata),
		.count     (one_hz_counter),
		.carry     (sec_wrap)
	); // see [R15] see [R4]

	rtc_wrap_counter #(.W(8)) u_minutes (
		.clk       (sys_clk),
		.rst       (rst),
		.inc       (sec_wrap),
		.wrap_val  (MINUTE_WRAP),
		.load      (wr_min),
		.load_data (sfr_wdata),
		.count     (per_sixty_s_counter),
		.carry     (min_wrap)
	); // see [R4]

	rtc_wrap_counter #(.W(8)) u_hours (
		.clk       (sys_clk),
		.rst       (rst),
		.inc       (min_wrap),
		.wrap_val  (hour_wrap_val),
		.load      (wr_hour),
		.load_data (sfr_wdata),
		.count     (hour_counter),
		.carry     (hour_wrap)
	); // see [R11] see [R4]

	// ------------------------------------------------------------------
	// Interval timer
	// ------------------------------------------------------------------
	assign ivl_run = interval_timer_on && clock_run_enable; // see [R17]

	always_comb begin
		case (interval_base_select) // see [R13]
			BASE_FRACTION: ivl_tick = fraction_tick;
			BASE_SECOND:   ivl_tick = frac_wrap;
			BASE_MINUTE:   ivl_tick = sec_wrap;
			BASE_HOUR:     ivl_tick = min_wrap;
			default:       ivl_tick = 1'b0;
		endcase
	end

	// A period of zero behaves like one: the alarm fires on every tick.
	always_comb begin
		next_ivl_state = ivl_state;
		next_ivl_count = ivl_count;
		alarm_event    = 1'b0;
		case (ivl_state)
			RTC_IVL_IDLE: begin
				next_ivl_count = 8'h00;
				if (ivl_run) begin
					next_ivl_state = RTC_IVL_COUNT;
				end
			end
			RTC_IVL_COUNT: begin
				if (!ivl_run) begin
					next_ivl_state = RTC_IVL_IDLE; // see [R17]
					next_ivl_count = 8'h00;
				end else if (ivl_tick) begin
					if (({1'b0, ivl_count} + 9'h001) >= {1'b0, alarm_period}) begin
						alarm_event    = 1'b1;
						next_ivl_count = 8'h00;
						if (single_shot_interval) begin
							next_ivl_state = RTC_IVL_DONE; // see [R16]
						end
					end else begin
						next_ivl_count = ivl_count + 8'h01;
					end
				end
			end
			RTC_IVL_DONE: begin
				next_ivl_count = 8'h00;
				if (!ivl_run) begin
					next_ivl_state = RTC_IVL_IDLE;
				end
			end
			default: begin
				next_ivl_state = RTC_IVL_IDLE;
				next_ivl_count = 8'h00;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst || warm_rst) begin
			ivl_state <= RTC_IVL_IDLE;
			ivl_count <= 8'h00;
		end else begin
			ivl_state <= next_ivl_state;
			ivl_count <= next_ivl_count;
		end
	end

	// ------------------------------------------------------------------
	// Control, flags and plain registers
	// ------------------------------------------------------------------
	always_comb begin
		next_key         = (sfr_wr_en && sfr_addr == ADDR_WRITE_UNLOCK_KEY) ? sfr_wdata
			: write_unlock_key; // see [R7]
		next_period      = (sfr_wr_en && sfr_addr == ADDR_ALARM_PERIOD) ? sfr_wdata
			: alarm_period;
		next_nominal     = (sfr_wr_en && sfr_addr == ADDR_NOMINAL_TRIM) ? sfr_wdata
			: crystal_nominal_trim;
		next_thermal     = (sfr_wr_en && sfr_addr == ADDR_THERMAL_TRIM) ? sfr_wdata
			: crystal_thermal_trim;
		next_pin_cfg     = (sfr_wr_en && unlocked && sfr_addr == ADDR_PIN_INTR_CONFIG)
			? sfr_wdata : pin_interrupt_config; // see [R6]
		next_day_wrap    = wr_ctrl ? sfr_wdata[CTRL_DAY_WRAP_BIT] : day_wrap_select;
		next_base        = wr_ctrl ? sfr_wdata[CTRL_BASE_HI_BIT:CTRL_BASE_LO_BIT]
			: interval_base_select;
		next_single_shot = wr_ctrl ? sfr_wdata[CTRL_SINGLE_SHOT_BIT] : single_shot_interval;
		next_ivl_on      = wr_ctrl ? sfr_wdata[CTRL_IVL_ON_BIT] : interval_timer_on;
		// Software can only clear the flags; a same-cycle event still sets them.
		next_midnight = midnight_flag;
		if (wr_ctrl && !sfr_wdata[CTRL_MIDNIGHT_BIT]) begin
			next_midnight = 1'b0;
		end
		if (hour_wrap) begin
			next_midnight = 1'b1; // see [R8] see [R9]
		end
		next_alarm = alarm_flag;
		if (wr_ctrl && !sfr_wdata[CTRL_ALARM_BIT]) begin
			next_alarm = 1'b0;
		end
		if (alarm_event) begin
			next_alarm = 1'b1; // see [R16]
		end
		next_block = next_midnight
			&& (deep_sleep_block || (hour_wrap && deep_sleep_state)); // see [R10]
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			day_wrap_select      <= CTRL_RESET[CTRL_DAY_WRAP_BIT]; // see [R12]
			midnight_flag        <= CTRL_RESET[CTRL_MIDNIGHT_BIT];
			deep_sleep_block     <= 1'b0;
			crystal_nominal_trim <= TRIM_RESET;
			crystal_thermal_trim <= TRIM_RESET;
		end else begin
			day_wrap_select      <= next_day_wrap;
			midnight_flag        <= next_midnight;
			deep_sleep_block     <= next_block;
			crystal_nominal_trim <= next_nominal;
			crystal_thermal_trim <= next_thermal;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || warm_rst) begin
			write_unlock_key     <= KEY_RESET;
			alarm_period         <= PERIOD_RESET;
			pin_interrupt_config <= PIN_CFG_RESET;
			interval_base_select <= CTRL_RESET[CTRL_BASE_HI_BIT:CTRL_BASE_LO_BIT];
			single_shot_interval <= CTRL_RESET[CTRL_SINGLE_SHOT_BIT];
			interval_timer_on    <= CTRL_RESET[CTRL_IVL_ON_BIT];
			alarm_flag           <= CTRL_RESET[CTRL_ALARM_BIT];
		end else begin
			write_unlock_key     <= next_key;
			alarm_period         <= next_period;
			pin_interrupt_config <= next_pin_cfg;
			interval_base_select <= next_base;
			single_shot_interval <= next_single_shot;
			interval_timer_on    <= next_ivl_on;
			alarm_flag           <= next_alarm;
		end
	end

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	assign ctrl_view = {midnight_flag, day_wrap_select, interval_base_select,
		single_shot_interval, alarm_flag, interval_timer_on, CTRL_RESET[CTRL_FIXED_BIT]};

	always_comb begin
		next_hit   = sfr_rd_en;
		next_rdata = 8'h00;
		case (sfr_addr)
			ADDR_RTC_CONTROL:      next_rdata = ctrl_view;
			ADDR_FRACTION_COUNTER: next_rdata = fraction_counter;
			ADDR_ONE_HZ_COUNTER:   next_rdata = one_hz_counter;
			ADDR_PER_SIXTY_S:      next_rdata = per_sixty_s_counter;
			ADDR_HOUR_COUNTER:     next_rdata = hour_counter;
			ADDR_ALARM_PERIOD:     next_rdata = alarm_period;
			ADDR_NOMINAL_TRIM:     next_rdata = crystal_nominal_trim;
			ADDR_THERMAL_TRIM:     next_rdata = crystal_thermal_trim;
			ADDR_WRITE_UNLOCK_KEY: next_rdata = write_unlock_key;
			ADDR_PIN_INTR_CONFIG:  next_rdata = pin_interrupt_config;
			default:               next_hit   = 1'b0;
		endcase
		if (!sfr_rd_en) begin
			next_rdata = 8'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
			sfr_hit   <= 1'b0;
		end else begin
			sfr_rdata <= next_rdata;
			sfr_hit   <= next_hit;
		end
	end

endmodule : rtc_timekeeping_unit

// ===== hw/rtc_wrap_counter.sv
// Purpose: One timekeeping digit counter with load and programmable wrap.
// Assumes: Cleared by power-on reset only.
// Notes:   A load in the same cycle as an increment wins and suppresses the carry.

`timescale 1ns/10ps

module rtc_wrap_counter
	import rtc_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         inc,
	input  wire logic [W-1:0] wrap_val,
	input  wire logic         load,
	input  wire logic [W-1:0] load_data,
	output logic      [W-1:0] count,
	output logic              carry
);

	logic [W-1:0] next_count;

	// A value above the wrap point, left by a load or a mode change, also wraps.
	assign carry = inc && !load && (count >= wrap_val);

	always_comb begin
		next_count = count;
		if (load) begin
			next_count = load_data;
		end else if (carry) begin
			next_count = '0;
		end else if (inc) begin
			next_count = count + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= W'(COUNTER_RESET);
		end else begin
			count <= next_count;
		end
	end

endmodule : rtc_wrap_counter

// ===== pkg/rtc_pkg.sv
// Purpose: Shared constants and types of the real-time clock timekeeping unit.
// Assumes: Registers are byte-wide special-function registers on the core's SFR port.
// Notes:   Every offset, field position, reset value and count is named here once.

package rtc_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_RTC_CONTROL       = 8'hA1;
	localparam logic [7:0] ADDR_FRACTION_COUNTER  = 8'hA2;
	localparam logic [7:0] ADDR_ONE_HZ_COUNTER    = 8'hA3;
	localparam logic [7:0] ADDR_PER_SIXTY_S       = 8'hA4;
	localparam logic [7:0] ADDR_HOUR_COUNTER      = 8'hA5;
	localparam logic [7:0] ADDR_ALARM_PERIOD      = 8'hA6;
	localparam logic [7:0] ADDR_NOMINAL_TRIM      = 8'hF6;
	localparam logic [7:0] ADDR_THERMAL_TRIM      = 8'hF7;
	localparam logic [7:0] ADDR_WRITE_UNLOCK_KEY  = 8'hC1;
	localparam logic [7:0] ADDR_PIN_INTR_CONFIG   = 8'hFF;

	localparam logic [7:0] UNLOCK_KEY_VALUE       = 8'hEA;

	// ------------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------------
	localparam int CTRL_MIDNIGHT_BIT    = 7;
	localparam int CTRL_DAY_WRAP_BIT    = 6;
	localparam int CTRL_BASE_HI_BIT     = 5;
	localparam int CTRL_BASE_LO_BIT     = 4;
	localparam int CTRL_SINGLE_SHOT_BIT = 3;
	localparam int CTRL_ALARM_BIT       = 2;
	localparam int CTRL_IVL_ON_BIT      = 1;
	localparam int CTRL_FIXED_BIT       = 0;

	localparam logic [1:0] BASE_FRACTION = 2'h0;
	localparam logic [1:0] BASE_SECOND   = 2'h1;
	localparam logic [1:0] BASE_MINUTE   = 2'h2;
	localparam logic [1:0] BASE_HOUR     = 2'h3;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET     = 8'h01;
	localparam logic [7:0] COUNTER_RESET  = 8'h00;
	localparam logic [7:0] KEY_RESET      = 8'h00;
	localparam logic [7:0] PERIOD_RESET   = 8'h00;
	localparam logic [7:0] TRIM_RESET     = 8'h00;
	localparam logic [7:0] PIN_CFG_RESET  = 8'h00;

	// ------------------------------------------------------------------
	// Counter wrap values
	// ------------------------------------------------------------------
	localparam logic [7:0] FRACTION_WRAP  = 8'h7F;
	localparam logic [7:0] SECOND_WRAP    = 8'h3B;
	localparam logic [7:0] MINUTE_WRAP    = 8'h3B;
	localparam logic [7:0] HOUR_WRAP_24   = 8'h17;
	localparam logic [7:0] HOUR_WRAP_256  = 8'hFF;

	// ------------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------------
	localparam int XTAL_FREQ_HZ     = 32768;
	localparam int FRACTION_RATE_HZ = 128;
	localparam int XTAL_PER_FRACTION = XTAL_FREQ_HZ / FRACTION_RATE_HZ;
	localparam int PRESCALE_W       = $clog2(XTAL_PER_FRACTION);
	localparam int CAL_ACC_W        = 12;
	// Trim units accumulated per second that make up one crystal edge.
	localparam logic signed [CAL_ACC_W-1:0] CAL_STEP_UNITS = 12'sh010;

	typedef enum logic [2:0] {
		RTC_IVL_IDLE  = 3'b001,
		RTC_IVL_COUNT = 3'b010,
		RTC_IVL_DONE  = 3'b100
	} rtc_ivl_state_t;

endpackage : rtc_pkg

// ===== test/rtc_timekeeping_unit_bench.sv
// Purpose: Self-checking bench for the timekeeping unit.
// Assumes: The crystal is modelled at a fast rate, two sys_clk per level.
// Notes:   The crystal is stopped while the time is loaded so no tick splits the load.

`timescale 1ns/10ps

module rtc_timekeeping_unit_bench
	import rtc_pkg::*;
;
	typedef struct {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} rtc_row_t;
	logic       sys_clk, rst, warm_rst, xtal_clk_in, clock_run_enable, deep_sleep_state;
	logic       sfr_wr_en, sfr_rd_en, sfr_hit, midnight_flag, alarm_flag, deep_sleep_block;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pin_interrupt_config;
	logic       xdiv, xtal_run;
	int         n_mismatch, checked, cycles;
	rtc_row_t   rows [12] = '{'{0, 8'hA1, 8'h00, 8'h01}, '{0, 8'hA2, 8'h00, 8'h00},
		'{0, 8'hA5, 8'h00, 8'h00}, '{0, 8'hA6, 8'h00, 8'h00}, '{0, 8'hF6, 8'h00, 8'h00},
		'{0, 8'hF7, 8'h00, 8'h00}, '{0, 8'h00, 8'h00, 8'h00}, '{1, 8'hA3, 8'h3B, 8'h3B},
		'{1, 8'hA6, 8'h05, 8'h05}, '{1, 8'hF6, 8'h10, 8'h10}, '{1, 8'hF7, 8'hF0, 8'hF0},
		'{1, 8'hA1, 8'hFF, 8'h7B}};

	rtc_timekeeping_unit DUT (.sys_clk(sys_clk), .rst(rst), .warm_rst(warm_rst),
		.xtal_clk_in(xtal_clk_in), .clock_run_enable(clock_run_enable),
		.deep_sleep_state(deep_sleep_state), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
		.sfr_wdata(sfr_wdata), .sfr_rd_en(sfr_rd_en), .sfr_rdata(sfr_rdata),
		.sfr_hit(sfr_hit), .midnight_flag(midnight_flag), .alarm_flag(alarm_flag),
		.deep_sleep_block(deep_sleep_block), .pin_interrupt_config(pin_interrupt_config));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// The crystal toggles every second sys_clk cycle while it runs.
	always @(posedge sys_clk) begin
		xdiv <= ~xdiv;
		if (xdiv && xtal_run) xtal_clk_in <= ~xtal_clk_in;
		cycles++;
		if (cycles == 60000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr_wr_en <= 1'b1;
		sfr_addr  <= a;
		sfr_wdata <= d;
		@(posedge sys_clk);
		sfr_wr_en <= 1'b0;
	endtask : wr

	task automatic wk(input logic [7:0] a, input logic [7:0] d);
		wr(ADDR_WRITE_UNLOCK_KEY, UNLOCK_KEY_VALUE);
		wr(a, d);
		wr(ADDR_WRITE_UNLOCK_KEY, 8'h00);
	endtask : wk

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		sfr_rd_en <= 1'b1;
		sfr_addr  <= a;
		@(posedge sys_clk);
		sfr_rd_en <= 1'b0;
		#1;
		check(sfr_rdata, e);
	endtask : rdc

	task automatic settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : settle

	task automatic wait_flag(input logic which, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge sys_clk);
			if ((which ? alarm_flag : midnight_flag) === 1'b1) break;
		end
		#1;
	endtask : wait_flag

	// Loads hh:59:59:127 with the crystal held so the next tick rolls the hour.
	task automatic set_day(input logic [7:0] h);
		xtal_run <= 1'b0;
		wk(ADDR_HOUR_COUNTER, h);
		wk(ADDR_PER_SIXTY_S, 8'h3B);
		wk(ADDR_ONE_HZ_COUNTER, 8'h3B);
		wk(ADDR_FRACTION_COUNTER, 8'h7F);
		xtal_run <= 1'b1;
	endtask : set_day

	task automatic finish_test;
		$display("checks %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{rst, warm_rst, xtal_clk_in, xdiv, sfr_wr_en, sfr_rd_en, deep_sleep_state} = 7'h40;
		{clock_run_enable, xtal_run, sfr_addr, sfr_wdata} = 18'h30000;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].wr) wk(rows[i].a, rows[i].d);
			rdc(rows[i].a, rows[i].e);
		end
		wr(ADDR_RTC_CONTROL, 8'h40);
		$display("test registers done");
		wr(ADDR_WRITE_UNLOCK_KEY, 8'h00);
		wr(ADDR_HOUR_COUNTER, 8'h07);
		wr(ADDR_PIN_INTR_CONFIG, 8'h80);
		rdc(ADDR_HOUR_COUNTER, 8'h00);
		check(pin_interrupt_config, 8'h00);
		wk(ADDR_HOUR_COUNTER, 8'h07);
		wk(ADDR_PIN_INTR_CONFIG, 8'h80);
		rdc(ADDR_HOUR_COUNTER, 8'h07);
		check(pin_interrupt_config, 8'h80);
		$display("test key done");
		deep_sleep_state <= 1'b1;
		set_day(8'h17);
		wait_flag(0, 1500);
		check({7'h00, midnight_flag}, 8'h01);
		check({7'h00, deep_sleep_block}, 8'h01);
		rdc(ADDR_HOUR_COUNTER, 8'h00);
		rdc(ADDR_PER_SIXTY_S, 8'h00);
		rdc(ADDR_ONE_HZ_COUNTER, 8'h00);
		deep_sleep_state <= 1'b0;
		wr(ADDR_RTC_CONTROL, 8'h00);
		settle();
		check({6'h00, midnight_flag, deep_sleep_block}, 8'h00);
		set_day(8'h17);
		wait_flag(0, 1300);
		check({7'h00, midnight_flag}, 8'h00);
		rdc(ADDR_HOUR_COUNTER, 8'h18);
		set_day(8'hFF);
		wait_flag(0, 1500);
		check({7'h00, midnight_flag}, 8'h01);
		rdc(ADDR_HOUR_COUNTER, 8'h00);
		$display("test rollover done");
		xtal_run <= 1'b0;
		wr(ADDR_RTC_CONTROL, 8'h40);
		wk(ADDR_HOUR_COUNTER, 8'h09);
		warm_rst <= 1'b1;
		settle();
		warm_rst <= 1'b0;
		rdc(ADDR_HOUR_COUNTER, 8'h09);
		rdc(ADDR_RTC_CONTROL, 8'h41);
		rst <= 1'b1;
		settle();
		rst <= 1'b0;
		rdc(ADDR_HOUR_COUNTER, 8'h00);
		rdc(ADDR_RTC_CONTROL, 8'h01);
		$display("test resets done");
		xtal_run <= 1'b1;
		wr(ADDR_ALARM_PERIOD, 8'h02);
		wr(ADDR_RTC_CONTROL, 8'h02);
		wait_flag(1, 3500);
		check({7'h00, alarm_flag}, 8'h01);
		wr(ADDR_RTC_CONTROL, 8'h02);
		settle();
		check({7'h00, alarm_flag}, 8'h00);
		wait_flag(1, 3500);
		check({7'h00, alarm_flag}, 8'h01);
		wr(ADDR_RTC_CONTROL, 8'h00);
		wr(ADDR_RTC_CONTROL, 8'h0A);
		wait_flag(1, 3500);
		check({7'h00, alarm_flag}, 8'h01);
		wr(ADDR_RTC_CONTROL, 8'h0A);
		wait_flag(1, 4000);
		check({7'h00, alarm_flag}, 8'h00);
		clock_run_enable <= 1'b0;
		wr(ADDR_RTC_CONTROL, 8'h00);
		wr(ADDR_RTC_CONTROL, 8'h02);
		wait_flag(1, 4000);
		check({7'h00, alarm_flag}, 8'h00);
		$display("test interval done");
		finish_test();
	end
endmodule : rtc_timekeeping_unit_bench

// ===== test/rtc_tku_props.sv
// Purpose: Concurrent checks on the ports of the timekeeping unit.
// Assumes: One clock domain; rst is synchronous and active high.
// Notes:   Bound to every instance of the top module.

`timescale 1ns/10ps

module rtc_tku_props
	import rtc_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       warm_rst,
	input wire logic       xtal_clk_in,
	input wire logic       clock_run_enable,
	input wire logic       deep_sleep_state,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr_en,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_rd_en,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_hit,
	input wire logic       midnight_flag,
	input wire logic       alarm_flag,
	input wire logic       deep_sleep_block,
	input wire logic [7:0] pin_interrupt_config
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------
	chk_idle_read_zero: assert property (!sfr_rd_en |=> sfr_rdata == 8'h00 && !sfr_hit)
		else $error("read data or hit without a read strobe");
	chk_mapped_hit: assert property (sfr_rd_en && sfr_addr == ADDR_HOUR_COUNTER
		|=> sfr_hit)
		else $error("mapped read gave no hit");
	chk_unmapped_miss: assert property (sfr_rd_en && sfr_addr == 8'h00
		|=> !sfr_hit && sfr_rdata == 8'h00)
		else $error("unmapped read answered");
	chk_ctrl_readback: assert property (sfr_rd_en && sfr_addr == ADDR_RTC_CONTROL |=>
		sfr_rdata[0] && sfr_rdata[7] == $past(midnight_flag) && sfr_rdata[2] == $past(alarm_flag))
		else $error("control read does not match flags");
	chk_pin_guarded: assert property ($changed(pin_interrupt_config) |->
		$past(warm_rst) || ($past(sfr_wr_en) && $past(sfr_addr) == ADDR_PIN_INTR_CONFIG))
		else $error("pin configuration changed without a write");

	// ------------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------------
	chk_midnight_holds: assert property (midnight_flag
		&& !(sfr_wr_en && sfr_addr == ADDR_RTC_CONTROL) |=> midnight_flag)
		else $error("midnight flag dropped on its own");
	chk_alarm_holds: assert property (alarm_flag && !warm_rst &&
		!(sfr_wr_en && sfr_addr == ADDR_RTC_CONTROL) |=> alarm_flag)
		else $error("alarm flag dropped on its own");
	chk_block_with_flag: assert property (deep_sleep_block |-> midnight_flag)
		else $error("sleep block without midnight flag");
	chk_block_rise: assert property ($rose(deep_sleep_block) |->
		midnight_flag && $past(deep_sleep_state))
		else $error("sleep block rose apart from midnight");

	cov_midnight: cover property ($rose(midnight_flag));
	cov_alarm: cover property ($rose(alarm_flag));
	cov_block: cover property ($rose(deep_sleep_block));
endmodule : rtc_tku_props

bind rtc_timekeeping_unit rtc_tku_props u_props (.sys_clk(sys_clk), .rst(rst),
	.warm_rst(warm_rst), .xtal_clk_in(xtal_clk_in), .clock_run_enable(clock_run_enable),
	.deep_sleep_state(deep_sleep_state), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
	.sfr_wdata(sfr_wdata), .sfr_rd_en(sfr_rd_en), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
	.midnight_flag(midnight_flag), .alarm_flag(alarm_flag),
	.deep_sleep_block(deep_sleep_block), .pin_interrupt_config(pin_interrupt_config));
